/* common/asa_defines.vh */
// Constants for the asynchronous serial adapter core
// Functional notes
// (RQ1) Transmit NRZ data, holding register bit 0 first, higher bits in order.
// (RQ2) Receive NRZ data LSB first, timed by internal rate or external clock.
// (RQ3) Receive clock pin: 16x input when external, drives internal 16x out otherwise.
// (RQ4) Transmitter runs only while clear-to-send is low; disabled when high.
// (RQ5) Terminal-ready output low when command bit 0 is 1, high when 0.
// (RQ6) Transfers only when selected and phase-two high; read/write sets direction.
// (RQ7) Enabled interrupt pulls interrupt low, sets status bit 7 and cause bit.
// (RQ8) Selects 00: write loads transmit holding, read returns receive holding.
// (RQ9) Receive holding: first bit in bit 0, unused high bits zero, no parity.
// (RQ10) Receive-full bit 3 sets on transfer in, clears on holding read.
// (RQ11) Transmit-empty bit 4 sets on move to shifter, clears on host write.
// (RQ12) Status bits 5 and 6 show carrier and set-ready, zero when pin high.
// (RQ13) Any modem input change interrupts at once unless command bit 0 is 0.
// (RQ14) Modem bits freeze after interrupt until status read, then update again.
// (RQ15) Parity, framing and overrun flags never cause an interrupt.
// (RQ16) Status bit 7 sets on any interrupt, clears on status read.
// (RQ17) Control bits 0 to 3 select external 1/16 or one of 15 rates.
// (RQ18) Control bit 4: 0 external receive clock 1/16, 1 transmitter rate.
// (RQ19) Control bits 5 and 6 select 5 to 8 data bits both ways.
// (RQ20) Control bit 7 chooses one, one and a half or two stop bits.
// (RQ21) Command bit 0 at 0 disables receiver, transmitter and all interrupts.
// (RQ22) Internal rates derive from the 1.8432 MHz reference on crystal input.
// (RQ23) Hardware reset clears command, control, status; transmit-empty set.
// (RQ24) Write to selects 01 clears command bits 4..0 and overrun only.
// (RQ25) Select decode of status, command and control; chip select high-low.
// (RQ26) Baud code zero is external; word code 00..11 gives 8,7,6,5 bits.
// (RQ27) Interrupt output open-drain active low, released when bit 7 clears.
`ifndef ASA_DEFINES_VH
`define ASA_DEFINES_VH
`define ASA_RS_DATA 2'h0
`define ASA_RS_STATUS 2'h1
`define ASA_RS_COMMAND 2'h2
`define ASA_RS_CONTROL 2'h3
`define ASA_ST_PARITY 0
`define ASA_ST_FRAMING 1
`define ASA_ST_OVERRUN 2
`define ASA_ST_RX_FULL 3
`define ASA_ST_TX_EMPTY 4
`define ASA_ST_CARRIER 5
`define ASA_ST_SET_READY 6
`define ASA_ST_IRQ 7
`define ASA_CT_RX_SRC 4
`define ASA_CT_STOP 7
`define ASA_CM_READY 0
`define ASA_CM_RX_IRQ_OFF 1
`define ASA_CM_PAR_EN 5
`define ASA_CM_PRESET_KEEP 8'he0
`define ASA_CM_TX_IRQ_ON 2'h1
`define ASA_CM_RTS_OFF 2'h0
`define ASA_CMD_RESET 8'h00
`define ASA_CTRL_RESET 8'h00
`define ASA_TICKS_BIT_LAST 6'h0f
`define ASA_TICKS_MID 6'h07
`define ASA_STOP_ONE 6'h10
`define ASA_STOP_ONE_HALF 6'h18
`define ASA_STOP_TWO 6'h20
`define ASA_WORD_MAX 4'h8
`define ASA_DIV_1 12'h900
`define ASA_DIV_2 12'h600
`define ASA_DIV_3 12'h418
`define ASA_DIV_4 12'h358
`define ASA_DIV_5 12'h300
`define ASA_DIV_6 12'h180
`define ASA_DIV_7 12'h0c0
`define ASA_DIV_8 12'h060
`define ASA_DIV_9 12'h040
`define ASA_DIV_10 12'h030
`define ASA_DIV_11 12'h020
`define ASA_DIV_12 12'h018
`define ASA_DIV_13 12'h010
`define ASA_DIV_14 12'h00c
`define ASA_DIV_15 12'h006
`endif

/* design/asa_core.v */
// Serial adapter core: pin synchroniser, receive FIFO and the adapter top
`include "asa_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for a group of pins
module asa_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b1}}
) (
   input wire clk,
   input wire rst,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Small FIFO with valid and ready on both sides
module asa_fifo #(
   parameter W = 9,
   parameter D = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst,
   input wire wr_valid,
   output wire wr_ready,
   input wire [W-1:0] wr_data,
   output wire rd_valid,
   input wire rd_ready,
   output wire [W-1:0] rd_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire do_wr;
   wire do_rd;

   assign wr_ready = (count != D[AW:0]);
   assign rd_valid = (count != {(AW+1){1'b0}});
   assign rd_data = mem[rd_ptr];
   assign do_wr = wr_valid & wr_ready;
   assign do_rd = rd_valid & rd_ready;

   // Pointers wrap by index so any depth up to 2**AW works
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            mem[wr_ptr] <= wr_data;
            wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd & ~do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Adapter top: processor bus, rate generator, transmitter, receiver, status
module asa_core #(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
) (
   input wire CLOCK,
   input wire RST_N,
   input wire HARDWARE_RESET_N,
   input wire PHI2,
   input wire SELECT_ACTIVE_HIGH,
   input wire SELECT_ACTIVE_LOW_N,
   input wire REG_SELECT_LO,
   input wire REG_SELECT_HI,
   input wire READ_WRITE,
   input wire [7:0] DATA_IN,
   output reg [7:0] DATA_OUT,
   output reg DATA_OE_N,
   output reg IRQ_OUT,
   output reg IRQ_OE_N,
   input wire CRYSTAL_IN,
   output reg TXD,
   input wire RXD,
   input wire RECEIVE_16X_CLOCK_IN,
   output reg RECEIVE_16X_CLOCK_OUT,
   output reg RECEIVE_16X_CLOCK_OE_N,
   output reg RTS_N,
   input wire CTS_N,
   output reg DTR_N,
   input wire DSR_N,
   input wire DCD_N
);
   localparam TX_IDLE = 2'h0;
   localparam TX_START = 2'h1;
   localparam TX_DATA = 2'h2;
   localparam TX_STOP = 2'h3;
   localparam RX_IDLE = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_DATA = 2'h2;
   localparam RX_STOP = 2'h3;

   wire rst_sys;
   wire rst;
   wire [20:0] pins_s;
   wire hw_rst_n_s, phi2_s, cs_hi_s, cs_lo_n_s, rs1_s, rs0_s, rw_s;
   wire [7:0] din_s;
   wire xtal_s, rxd_s, rxc_s, cts_n_s, dsr_n_s, dcd_n_s;
   reg phi2_d, xtal_d, rxc_d;
   reg [7:0] cmd, ctrl, thr, rhr, status;
   reg thr_full, rdrf, fe, ovr, irq_bit, carrier, set_ready, frozen;
   reg [11:0] div_cnt, div_val;
   reg tx_tick;
   reg [1:0] tx_state, rx_state;
   reg [5:0] tx_cnt, rx_cnt, stop_ticks;
   reg [3:0] tx_bit, rx_bit;
   reg [7:0] tx_shift, rx_shift;
   wire selected, acc_rise, acc_fall, xtal_rise, rx_tick, rx_en, tx_en, tx_free;
   wire [1:0] rs;
   wire [3:0] nbits;
   wire [7:0] rx_word;
   wire fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
   wire [8:0] fifo_rd_data;
   reg fifo_push;
   wire status_rd, rhr_rd, thr_wr, tx_load, rdrf_set, modem_evt, irq_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Pins and reset
   assign rst_sys = ~RST_N;
   asa_sync #(.W(21), .INIT(21'h1fffff)) u_sync (
      .clk(CLOCK),
      .rst(rst_sys),
      .d({HARDWARE_RESET_N, PHI2, SELECT_ACTIVE_HIGH, SELECT_ACTIVE_LOW_N, REG_SELECT_HI,
          REG_SELECT_LO, READ_WRITE, DATA_IN, CRYSTAL_IN, RXD, RECEIVE_16X_CLOCK_IN,
          CTS_N, DSR_N, DCD_N}),
      .q(pins_s)
   );
   assign {hw_rst_n_s, phi2_s, cs_hi_s, cs_lo_n_s, rs1_s, rs0_s, rw_s, din_s, xtal_s,
           rxd_s, rxc_s, cts_n_s, dsr_n_s, dcd_n_s} = pins_s;
   // Pin reset is sampled, so it acts a few clocks late but never glitches state
   assign rst = rst_sys | ~hw_rst_n_s; // see (RQ23)

   // Edge detectors read only the synchronised copies
   always @(posedge CLOCK) begin
      if (rst_sys) begin
         phi2_d <= 1'b1;
         xtal_d <= 1'b1;
         rxc_d <= 1'b1;
      end else begin
         phi2_d <= phi2_s;
         xtal_d <= xtal_s;
         rxc_d <= rxc_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Processor bus decode
   assign selected = cs_hi_s & ~cs_lo_n_s; // see (RQ25)
   assign rs = {rs1_s, rs0_s};
   // Reads act at the start of phase two, writes at its end when data is settled
   assign acc_rise = phi2_s & ~phi2_d & selected & rw_s; // see (RQ6)
   assign acc_fall = ~phi2_s & phi2_d & selected & ~rw_s; // see (RQ6)
   assign status_rd = acc_rise & (rs == `ASA_RS_STATUS);
   assign rhr_rd = acc_rise & (rs == `ASA_RS_DATA); // see (RQ8)
   assign thr_wr = acc_fall & (rs == `ASA_RS_DATA); // see (RQ8)

   // Status image assembled from live flags
   always @* begin
      status = 8'h00;
      status[`ASA_ST_PARITY] = 1'b0;
      status[`ASA_ST_FRAMING] = fe;
      status[`ASA_ST_OVERRUN] = ovr;
      status[`ASA_ST_RX_FULL] = rdrf;
      status[`ASA_ST_TX_EMPTY] = ~thr_full;
      status[`ASA_ST_CARRIER] = carrier;
      status[`ASA_ST_SET_READY] = set_ready;
      status[`ASA_ST_IRQ] = irq_bit;
   end

   // Bus driver: data is snapshot at the start so side effects do not tear it
   always @(posedge CLOCK) begin
      if (rst) begin
         DATA_OUT <= 8'h00;
         DATA_OE_N <= 1'b1;
      end else begin
         DATA_OE_N <= ~(phi2_s & selected & rw_s); // see (RQ6)
         if (acc_rise) begin
            if (rs == `ASA_RS_DATA) begin
               DATA_OUT <= rhr; // see (RQ8)
            end else if (rs == `ASA_RS_STATUS) begin
               DATA_OUT <= status;
            end else if (rs == `ASA_RS_COMMAND) begin
               DATA_OUT <= cmd;
            end else begin
               DATA_OUT <= ctrl;
            end
         end
      end
   end

   // Command and control registers; programmed reset keeps control intact
   always @(posedge CLOCK) begin
      if (rst) begin
         cmd <= `ASA_CMD_RESET;
         ctrl <= `ASA_CTRL_RESET;
      end else if (acc_fall) begin
         if (rs == `ASA_RS_STATUS) begin
            cmd <= cmd & `ASA_CM_PRESET_KEEP; // see (RQ24)
         end else if (rs == `ASA_RS_COMMAND) begin
            cmd <= din_s;
         end else if (rs == `ASA_RS_CONTROL) begin
            ctrl <= din_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Rate generator counting crystal edges
   assign xtal_rise = xtal_s & ~xtal_d;

   // Divisor per 16x tick of the 1.8432 MHz reference
   always @* begin
      case (ctrl[3:0])
         4'h1: div_val = `ASA_DIV_1;
         4'h2: div_val = `ASA_DIV_2;
         4'h3: div_val = `ASA_DIV_3;
         4'h4: div_val = `ASA_DIV_4;
         4'h5: div_val = `ASA_DIV_5;
         4'h6: div_val = `ASA_DIV_6;
         4'h7: div_val = `ASA_DIV_7;
         4'h8: div_val = `ASA_DIV_8;
         4'h9: div_val = `ASA_DIV_9;
         4'ha: div_val = `ASA_DIV_10;
         4'hb: div_val = `ASA_DIV_11;
         4'hc: div_val = `ASA_DIV_12;
         4'hd: div_val = `ASA_DIV_13;
         4'he: div_val = `ASA_DIV_14;
         4'hf: div_val = `ASA_DIV_15;
         default: div_val = 12'h001;
      endcase
   end

   // Code zero passes every rising crystal edge: the external clock is taken as 16x
   always @(posedge CLOCK) begin
      if (rst) begin
         div_cnt <= 12'h000;
         tx_tick <= 1'b0;
      end else begin
         tx_tick <= 1'b0;
         if (xtal_rise) begin
            if (ctrl[3:0] == 4'h0) begin
               tx_tick <= 1'b1; // see (RQ17) see (RQ26)
               div_cnt <= 12'h000;
            end else if (div_cnt >= div_val - 12'h001) begin
               tx_tick <= 1'b1; // see (RQ22) see (RQ17)
               div_cnt <= 12'h000;
            end else begin
               div_cnt <= div_cnt + 12'h001;
            end
         end
      end
   end

   // Receive clock source and the shared clock pin
   assign rx_tick = ctrl[`ASA_CT_RX_SRC] ? tx_tick : (rxc_s & ~rxc_d); // see (RQ18) see (RQ2)
   always @(posedge CLOCK) begin
      if (rst) begin
         RECEIVE_16X_CLOCK_OUT <= 1'b0;
         RECEIVE_16X_CLOCK_OE_N <= 1'b1;
      end else begin
         RECEIVE_16X_CLOCK_OUT <= tx_tick; // see (RQ3)
         RECEIVE_16X_CLOCK_OE_N <= ~ctrl[`ASA_CT_RX_SRC]; // see (RQ3)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame format
   assign nbits = `ASA_WORD_MAX - {2'b00, ctrl[6:5]}; // see (RQ19) see (RQ26)
   always @* begin
      if (!ctrl[`ASA_CT_STOP]) begin
         stop_ticks = `ASA_STOP_ONE; // see (RQ20)
      end else if ((nbits == 4'h5) && !cmd[`ASA_CM_PAR_EN]) begin
         stop_ticks = `ASA_STOP_ONE_HALF; // see (RQ20)
      end else if ((nbits == 4'h8) && cmd[`ASA_CM_PAR_EN]) begin
         stop_ticks = `ASA_STOP_ONE;
      end else begin
         stop_ticks = `ASA_STOP_TWO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   assign tx_en = cmd[`ASA_CM_READY] & ~cts_n_s; // see (RQ4) see (RQ21)
   assign tx_free = (tx_state == TX_IDLE) ||
                    ((tx_state == TX_STOP) && (tx_cnt == stop_ticks - 6'h01));
   assign tx_load = tx_en & tx_tick & tx_free & thr_full;

   // A write in the load cycle wins: the shifter takes the old byte
   always @(posedge CLOCK) begin
      if (rst) begin
         thr <= 8'h00;
         thr_full <= 1'b0; // see (RQ23)
      end else begin
         if (tx_load) begin
            thr_full <= 1'b0; // see (RQ11)
         end
         if (thr_wr) begin
            thr <= din_s;
            thr_full <= 1'b1; // see (RQ11)
         end
      end
   end

   // Clear-to-send high drops the line to mark at once and abandons the byte
   always @(posedge CLOCK) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_cnt <= 6'h00;
         tx_bit <= 4'h0;
         tx_shift <= 8'h00;
         TXD <= 1'b1;
      end else if (!tx_en) begin
         tx_state <= TX_IDLE; // see (RQ4)
         TXD <= 1'b1;
      end else if (tx_load) begin
         tx_shift <= thr;
         tx_state <= TX_START;
         tx_cnt <= 6'h00;
         TXD <= 1'b0;
      end else if (tx_tick) begin
         tx_cnt <= tx_cnt + 6'h01;
         case (tx_state)
            TX_START: begin
               if (tx_cnt == `ASA_TICKS_BIT_LAST) begin
                  tx_state <= TX_DATA;
                  tx_cnt <= 6'h00;
                  tx_bit <= 4'h0;
                  TXD <= tx_shift[0]; // see (RQ1)
               end
            end
            TX_DATA: begin
               if (tx_cnt == `ASA_TICKS_BIT_LAST) begin
                  tx_cnt <= 6'h00;
                  if (tx_bit == nbits - 4'h1) begin
                     tx_state <= TX_STOP;
                     TXD <= 1'b1;
                  end else begin
                     tx_bit <= tx_bit + 4'h1;
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     TXD <= tx_shift[1]; // see (RQ1)
                  end
               end
            end
            TX_STOP: begin
               if (tx_free) begin
                  tx_state <= TX_IDLE;
               end
            end
            default: begin
               TXD <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver, sampling each bit at its middle tick
   assign rx_en = cmd[`ASA_CM_READY]; // see (RQ21)
   assign rx_word = rx_shift >> (`ASA_WORD_MAX - nbits); // see (RQ9)

   always @(posedge CLOCK) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 6'h00;
         rx_bit <= 4'h0;
         rx_shift <= 8'h00;
         fifo_push <= 1'b0;
      end else begin
         fifo_push <= 1'b0;
         if (!rx_en) begin
            rx_state <= RX_IDLE;
         end else if (rx_tick) begin
            rx_cnt <= rx_cnt + 6'h01;
            case (rx_state)
               RX_IDLE: begin
                  if (!rxd_s) begin
                     rx_state <= RX_START;
                     rx_cnt <= 6'h00;
                  end
               end
               RX_START: begin
                  if (rx_cnt == `ASA_TICKS_MID) begin
                     rx_state <= rxd_s ? RX_IDLE : RX_DATA;
                     rx_cnt <= 6'h00;
                     rx_bit <= 4'h0;
                     rx_shift <= 8'h00;
                  end
               end
               RX_DATA: begin
                  if (rx_cnt == `ASA_TICKS_BIT_LAST) begin
                     rx_cnt <= 6'h00;
                     rx_shift <= {rxd_s, rx_shift[7:1]}; // see (RQ2)
                     rx_bit <= rx_bit + 4'h1;
                     if (rx_bit == nbits - 4'h1) begin
                        rx_state <= RX_STOP;
                     end
                  end
               end
               default: begin
                  if (rx_cnt == `ASA_TICKS_BIT_LAST) begin
                     rx_state <= RX_IDLE;
                     fifo_push <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Framing flag travels with its byte; rxd is still the stop sample here
   asa_fifo #(.W(9), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
      .clk(CLOCK),
      .rst(rst),
      .wr_valid(fifo_push),
      .wr_ready(fifo_wr_ready),
      .wr_data({~rxd_s, rx_word}),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );
   // Holding register drains the FIFO only when empty, so a slow host fills it
   assign fifo_rd_ready = ~rdrf;
   assign rdrf_set = fifo_rd_valid & ~rdrf;

   always @(posedge CLOCK) begin
      if (rst) begin
         rhr <= 8'h00;
         rdrf <= 1'b0;
         fe <= 1'b0;
         ovr <= 1'b0;
      end else begin
         if (rdrf_set) begin
            rhr <= fifo_rd_data[7:0];
            fe <= fifo_rd_data[8];
            rdrf <= 1'b1; // see (RQ10)
         end else if (rhr_rd) begin
            rdrf <= 1'b0; // see (RQ10)
         end
         // Lost byte when the FIFO is full; the set wins over programmed reset
         if (fifo_push & ~fifo_wr_ready) begin
            ovr <= 1'b1;
         end else if (acc_fall && (rs == `ASA_RS_STATUS)) begin
            ovr <= 1'b0; // see (RQ24)
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modem inputs, interrupt flag and line controls
   assign modem_evt = cmd[`ASA_CM_READY] & ~frozen & ~status_rd &
                      ((carrier != ~dcd_n_s) | (set_ready != ~dsr_n_s)); // see (RQ13)

   // Bits freeze on a change and thaw on a status read; a pending change then fires
   always @(posedge CLOCK) begin
      if (rst) begin
         carrier <= 1'b0;
         set_ready <= 1'b0;
         frozen <= 1'b0;
      end else if (!cmd[`ASA_CM_READY] || (!frozen && !status_rd)) begin
         carrier <= ~dcd_n_s; // see (RQ12)
         set_ready <= ~dsr_n_s; // see (RQ12)
         frozen <= modem_evt; // see (RQ14)
      end else if (status_rd) begin
         frozen <= 1'b0; // see (RQ14)
      end
   end

   // Error flags are left out of the cause terms on purpose
   assign irq_evt = cmd[`ASA_CM_READY] & ((rdrf_set & ~cmd[`ASA_CM_RX_IRQ_OFF]) |
                    (tx_load & (cmd[3:2] == `ASA_CM_TX_IRQ_ON)) | modem_evt); // see (RQ15)

   // A cause in the read cycle wins over the clear
   always @(posedge CLOCK) begin
      if (rst) begin
         irq_bit <= 1'b0;
      end else if (irq_evt) begin
         irq_bit <= 1'b1; // see (RQ16) see (RQ7) see (RQ21)
      end else if (status_rd) begin
         irq_bit <= 1'b0; // see (RQ16)
      end
   end

   // Open-drain request follows bit 7 one clock later
   always @(posedge CLOCK) begin
      if (rst) begin
         IRQ_OUT <= 1'b0;
         IRQ_OE_N <= 1'b1;
         DTR_N <= 1'b1;
         RTS_N <= 1'b1;
      end else begin
         IRQ_OUT <= 1'b0;
         IRQ_OE_N <= ~irq_bit; // see (RQ27) see (RQ7)
         DTR_N <= ~cmd[`ASA_CM_READY]; // see (RQ5)
         RTS_N <= (cmd[3:2] == `ASA_CM_RTS_OFF);
      end
   end
endmodule

/* tb/asa_props.sv */
// Port checker for the serial adapter core
module asa_props (
   input wire CLOCK,
   input wire RST_N,
   input wire HARDWARE_RESET_N,
   input wire PHI2,
   input wire SELECT_ACTIVE_HIGH,
   input wire READ_WRITE,
   input wire CTS_N,
   input logic [7:0] DATA_OUT,
   input logic DATA_OE_N,
   input logic IRQ_OUT,
   input logic IRQ_OE_N,
   input logic TXD,
   input logic DTR_N,
   input logic RECEIVE_16X_CLOCK_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N || !HARDWARE_RESET_N);
   irq_drain_a: assert property (IRQ_OUT == 1'b0)
      else $error("interrupt data not low");
   read_drive_a: assert property ($fell(DATA_OE_N) |-> $past(PHI2, 2) && $past(READ_WRITE, 2))
      else $error("bus driven without read");
   idle_bus_a: assert property (!PHI2 [*5] |-> DATA_OE_N)
      else $error("bus driven with phase two low");
   unselected_a: assert property (!SELECT_ACTIVE_HIGH [*5] |-> DATA_OE_N)
      else $error("bus driven while deselected");
   read_hold_a: assert property (!PHI2 [*4] |-> $stable(DATA_OUT))
      else $error("read data moved");
   cts_mark_a: assert property (CTS_N [*5] |=> TXD)
      else $error("transmit with clear to send high");
   off_mark_a: assert property (DTR_N [*4] |=> TXD)
      else $error("transmit while disabled");
   off_quiet_a: assert property ($fell(IRQ_OE_N) |-> !DTR_N)
      else $error("interrupt while disabled");
   rxclk_pulse_a: assert property (RECEIVE_16X_CLOCK_OUT |=> !RECEIVE_16X_CLOCK_OUT)
      else $error("receive clock pulse too long");
   reset_state_a: assert property (disable iff (1'b0) !RST_N |=> TXD && DTR_N && IRQ_OE_N)
      else $error("outputs wrong in reset");
endmodule

/* tb/asa_modem.sv */
// Modem model: frames characters onto receive data, decodes transmit data
module asa_modem #(
   parameter BIT = 64
) (
   input wire clock,
   input wire txd,
   input wire [3:0] nbits,
   output logic rxd,
   output logic got,
   output logic [7:0] got_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   integer i;
   // Idle line rests at mark
   initial begin
      rxd = 1'b1;
      got = 1'b0;
      got_byte = 8'h00;
   end
   // One frame, low bit first, one stop bit
   task send(input logic [7:0] d, input integer n);
      integer k;
      @(negedge clock);
      rxd = 1'b0;
      for (k = 0; k <= n; k++) begin
         repeat (BIT) @(negedge clock);
         rxd = (k == n) ? 1'b1 : d[k];
      end
      repeat (BIT) @(negedge clock);
   endtask
   // Sample transmit data mid-bit; negedge updates keep the bench race free
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(negedge clock);
      got_byte = 8'h00;
      for (i = 0; i < nbits; i++) begin
         repeat (BIT) @(negedge clock);
         got_byte[i] = txd;
      end
      got = 1'b1;
      @(negedge clock);
      got = 1'b0;
   end
endmodule

/* tb/tb.sv */
// Self-checking bench for the serial adapter core
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n = 0, phi2 = 0, sel = 0, rs_lo = 0, rs_hi = 0, rw = 1, crystal = 0;
   logic cts_n = 0, dsr_n = 1, dcd_n = 1, hw_rst_n = 1, got;
   logic [7:0] din = 8'h00, dout, rd_val, d, got_byte;
   logic [3:0] nbits = 4'h8;
   logic doe_n, irq_o, irq_oe_n, txd, rxd, rxc_o, rxc_oe_n, rts_n, dtr_n;
   logic [7:0] rd_q[$], tx_q[$];
   integer num_errors = 0, check_count = 0, seed = 60296, wc;
   event rd_ev;
   asa_core u_asa_core (.CLOCK(clock), .RST_N(rst_n), .HARDWARE_RESET_N(hw_rst_n), .PHI2(phi2),
      .SELECT_ACTIVE_HIGH(sel), .SELECT_ACTIVE_LOW_N(~sel), .REG_SELECT_LO(rs_lo),
      .REG_SELECT_HI(rs_hi), .READ_WRITE(rw), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE_N(doe_n), .IRQ_OUT(irq_o), .IRQ_OE_N(irq_oe_n), .CRYSTAL_IN(crystal),
      .TXD(txd), .RXD(rxd), .RECEIVE_16X_CLOCK_IN(1'b0), .RECEIVE_16X_CLOCK_OUT(rxc_o),
      .RECEIVE_16X_CLOCK_OE_N(rxc_oe_n), .RTS_N(rts_n), .CTS_N(cts_n), .DTR_N(dtr_n),
      .DSR_N(dsr_n), .DCD_N(dcd_n));
   asa_modem u_asa_modem (.clock(clock), .txd(txd), .nbits(nbits), .rxd(rxd), .got(got),
      .got_byte(got_byte));
   ////////////////////////////////////////////////////////////////////////////////
   // Clocks: crystal ticks every 4 cycles so a bit is 64 cycles
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial forever begin
      repeat (2) @(negedge clock);
      crystal = ~crystal;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; the released data bus shows the inverse pattern
   task acc(input logic r, input logic [1:0] rs, input logic [7:0] v);
      @(negedge clock);
      sel = 1'b1;
      {rs_hi, rs_lo} = rs;
      rw = r;
      din = v;
      phi2 = 1'b1;
      repeat (8) @(negedge clock);
      if (r) begin
         rd_val = dout;
         -> rd_ev;
      end
      phi2 = 1'b0;
      repeat (4) @(negedge clock);
      sel = 1'b0;
      din = ~v;
   endtask
   task rd(input logic [1:0] rs, input logic [7:0] e);
      rd_q.push_back(e);
      acc(1'b1, rs, 8'h00);
   endtask
   task waitirq;
      integer t;
      for (t = 0; t < 400 && irq_oe_n !== 1'b0; t++) @(negedge clock);
      check({7'h0, irq_oe_n}, 8'h00);
   endtask
   // Result watchers take the oldest note
   always @(rd_ev) check(rd_val, rd_q.pop_front());
   always @(posedge clock) if (got === 1'b1) check(got_byte, tx_q.pop_front());
   task print_verdict;
      if (num_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Long enough for all frames; a hang counts as a failure
   initial begin
      #2000000;
      num_errors++;
      print_verdict;
   end
   // Main sequence
   initial begin
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      rd(2'h1, 8'h10);
      rd(2'h3, 8'h00);
      acc(1'b0, 2'h2, 8'h09);
      rd(2'h2, 8'h09);
      check({7'h0, dtr_n}, 8'h00);
      for (wc = 0; wc < 4; wc++) begin
         d = $random(seed);
         acc(1'b0, 2'h3, {1'b0, wc[1:0], 5'h10});
         rd(2'h3, {1'b0, wc[1:0], 5'h10});
         check({7'h0, rxc_oe_n}, 8'h00);
         nbits = 4'(8 - wc);
         tx_q.push_back(d & (8'hff >> wc));
         acc(1'b0, 2'h0, d);
         for (int t = 0; t < 2000 && tx_q.size() != 0; t++) @(negedge clock);
         check(8'(tx_q.size()), 8'h00);
         repeat (128) @(negedge clock); // Last bit and stop end before the format changes
      end
      d = $random(seed);
      u_asa_modem.send(d, 5);
      waitirq;
      rd(2'h1, 8'h98);
      rd(2'h0, d & 8'h1f);
      rd(2'h1, 8'h10);
      dcd_n = 1'b0;
      waitirq;
      dsr_n = 1'b0;
      repeat (8) @(negedge clock);
      rd(2'h1, 8'hb0);
      rd(2'h1, 8'hf0);
      rd(2'h1, 8'h70);
      acc(1'b0, 2'h1, 8'hff);
      rd(2'h2, 8'h00);
      rd(2'h3, 8'h70);
      check({7'h0, dtr_n}, 8'h01);
      cts_n = 1'b1;
      acc(1'b0, 2'h2, 8'h09);
      acc(1'b0, 2'h0, d);
      repeat (100) @(negedge clock);
      check({7'h0, txd}, 8'h01);
      rd(2'h1, 8'h60);
      // Mid-run pin reset: registers return to their reset values
      hw_rst_n = 1'b0;
      repeat (8) @(negedge clock);
      hw_rst_n = 1'b1;
      repeat (6) @(negedge clock);
      rd(2'h1, 8'h70);
      rd(2'h2, 8'h00);
      rd(2'h3, 8'h00);
      check({5'h0, dtr_n, rts_n, rxc_oe_n}, 8'h07);
      print_verdict;
   end
endmodule
bind asa_core asa_props u_asa_props (.CLOCK(CLOCK), .RST_N(RST_N),
   .HARDWARE_RESET_N(HARDWARE_RESET_N), .PHI2(PHI2),
   .SELECT_ACTIVE_HIGH(SELECT_ACTIVE_HIGH), .READ_WRITE(READ_WRITE), .CTS_N(CTS_N),
   .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .IRQ_OUT(IRQ_OUT), .IRQ_OE_N(IRQ_OE_N),
   .TXD(TXD), .DTR_N(DTR_N), .RECEIVE_16X_CLOCK_OUT(RECEIVE_16X_CLOCK_OUT));
